// ---- design/ppio_pkg.sv ----
// Package with register map, field positions and carrier types of the parallel I/O port.
package ppio_pkg;

    localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h1;
    localparam logic [3:0] ADDR_IO_CONFIG = 4'h2;
    localparam logic [3:0] ADDR_SCAN_CTRL = 4'h3;
    localparam logic [3:0] ADDR_SERIAL_DATA = 4'h4;
    localparam logic [3:0] ADDR_CHANNEL = 4'h5;

    localparam int BIT_EXT_IRQ0 = 0;
    localparam int BIT_OUT_STROBE = 1;
    localparam int BIT_IN_STROBE = 2;
    localparam int BIT_SER_OUT_EMPTY = 3;
    localparam int BIT_SER_IN_FULL = 4;
    localparam int BIT_IRQ_EN_LO = 5;
    localparam int BIT_IRQ_EN_HI = 9;
    localparam int BIT_IN_ACTIVE = 11;
    localparam int BIT_OUT_ACTIVE = 12;
    localparam int BIT_ALT_SERIAL_SELECT = 10;
    localparam int BIT_SW_LOOPBACK = 0;
    localparam int BIT_SCAN_LOOPBACK = 0;

    localparam logic [15:0] CTRL_STATUS_RESET = 16'h0008;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'h1BE0;
    localparam logic [15:0] IO_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] IO_CONFIG_WRITE_MASK = 16'h0401;

    localparam int ACTIVE_STROBE_CYCLES = 2;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ppio_req_s;

    typedef struct packed {
        logic [7:0] o;
        logic oe;
    } ppio_bus_s;

endpackage : ppio_pkg

// ---- design/ppio_port.sv ----
// Parallel I/O port with shared pending-interrupt status and internal loopback.
//
// Operation
// [RL1] Serial input full shows; cleared by serial read.
// [RL2] Serial output empty shows; cleared by serial write.
// [RL3] Passive external write sets flag; data read clears.
// [RL4] Clearing read in passive mode starts no transaction.
// [RL5] Passive external read sets flag; data write clears.
// [RL6] Pin irq sets unmasked; acknowledge fall clears; code clears only on the first acknowledge fall after irq_return.
// [RL7] Interrupt enable change takes effect one cycle late.
// [RL8] Bus driven only while output strobe low.
// [RL9] Both active: select drives three-bit channel.
// [RL10] Any passive: top select is low-active chip select.
// [RL11] Active output: low two selects name channel.
// [RL12] Passive output: middle select picks status or data.
// [RL13] Lowest select always output; OR of flags passive.
// [RL14] Input strobe low-active; sampled on rising edge.
// [RL15] Output strobe low-active; passive low drives bus.
// [RL16] Input full: cleared active, set after rise, read clears.
// [RL17] Output empty: cleared active, set after rise, write clears.
// [RL18] Port selected when alternate serial select is zero.
// [RL19] Loopback from scan bit or software bit.
// [RL20] Software sets output active, input passive for loopback.
// [RL21] Loopback floats pins, output strobe feeds input register.
// [RL22] Software spaces loopback writes for interrupt service.
// [RL23] Reset clears control except serial output empty.
// [RL24] Bits nine to five enable five interrupts.
// [RL25] Bits twelve and eleven make strobes outputs.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ppio_port (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic jtag_scan_wr,
    input wire logic jtag_scan_loopback,
    input wire logic serial_in_loaded,
    input wire logic serial_out_sent,
    input wire logic ext_irq0_pin,
    input wire logic interrupt_acknowledge,
    input wire logic irq_return,
    output logic irq_request,
    input wire logic [7:0] parallel_bus_i,
    output logic [7:0] parallel_bus_o,
    output logic parallel_bus_oe,
    input wire logic [2:0] peripheral_select_i,
    output logic [2:0] peripheral_select_o,
    output logic [2:0] peripheral_select_oe,
    input wire logic input_strobe_n_i,
    output logic input_strobe_n_o,
    output logic input_strobe_n_oe,
    input wire logic output_strobe_n_i,
    output logic output_strobe_n_o,
    output logic output_strobe_n_oe,
    output logic input_buffer_full,
    output logic output_buffer_empty,
    output logic port_pins_selected
);

    ppio_pkg::ppio_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [15:0] ctrl_q;
    logic [15:0] io_config_q;
    logic scan_loopback_q;
    logic [4:0] irq_en_eff_q;
    logic [7:0] out_data_q;
    logic [7:0] in_data_q;
    logic [2:0] channel_q;
    logic [15:0] reg_rdata_q;
    logic ibf_q;
    logic obe_q;
    logic [2:0] ids_sync_q;
    logic [2:0] ods_sync_q;
    logic [2:0] irq_sync_q;
    logic [2:0] ack_sync_q;
    logic [2:0] cs_sync_q;
    logic [2:0] ps1_sync_q;
    logic [7:0] pb_s1_q;
    logic [7:0] pb_s2_q;
    logic ids_lvl_q;
    logic ods_lvl_q;
    logic irq_lvl_q;
    logic ack_lvl_q;
    logic cs_lvl_q;
    logic ps1_lvl_q;
    logic ids_rise_d1_q;
    logic ods_rise_d1_q;
    logic ack_fell_pending_q;
    logic [1:0] wr_cnt_q;
    logic act_wr_q;
    logic [1:0] rd_cnt_q;
    logic act_rd_q;
    logic act_rd_cap_q;

    wire out_active = ctrl_q[ppio_pkg::BIT_OUT_ACTIVE];
    wire in_active = ctrl_q[ppio_pkg::BIT_IN_ACTIVE];
    wire loopback = scan_loopback_q | io_config_q[ppio_pkg::BIT_SW_LOOPBACK]; // RL19
    wire pins_on = ~io_config_q[ppio_pkg::BIT_ALT_SERIAL_SELECT]; // RL18
    wire both_active = out_active & in_active;
    wire both_passive = ~out_active & ~in_active;

    wire wr_ctrl = req.wr && req.addr == ppio_pkg::ADDR_CTRL_STATUS;
    wire wr_data = req.wr && req.addr == ppio_pkg::ADDR_DATA;
    wire wr_iocfg = req.wr && req.addr == ppio_pkg::ADDR_IO_CONFIG;
    wire wr_ser = req.wr && req.addr == ppio_pkg::ADDR_SERIAL_DATA;
    wire wr_chan = req.wr && req.addr == ppio_pkg::ADDR_CHANNEL;
    wire rd_data = req.rd && req.addr == ppio_pkg::ADDR_DATA;
    wire rd_ser = req.rd && req.addr == ppio_pkg::ADDR_SERIAL_DATA;

    // Pin inputs: three flops, a change counts once stages two and three agree.
    wire ids_agree = ids_sync_q[1] == ids_sync_q[2];
    wire ods_agree = ods_sync_q[1] == ods_sync_q[2];
    wire ids_pin_rise = ids_agree && ids_sync_q[2] && !ids_lvl_q;
    wire ods_pin_rise = ods_agree && ods_sync_q[2] && !ods_lvl_q;
    wire chip_sel = !cs_lvl_q; // RL10
    wire ack_fall = ack_sync_q[1] == ack_sync_q[2] && !ack_sync_q[2] && ack_lvl_q;
    wire irq_rise = irq_sync_q[1] == irq_sync_q[2] && irq_sync_q[2] && !irq_lvl_q;

    // In loopback the active write strobe stands in for the passive input strobe.
    wire act_wr_end = act_wr_q && wr_cnt_q == 2'd0;
    wire ids_event = loopback ? (act_wr_end && !in_active) : (pins_on && !in_active && chip_sel && ids_pin_rise); // RL14 RL21
    wire ods_event = pins_on && !loopback && !out_active && chip_sel && ods_pin_rise; // RL15
    wire act_rd_end = act_rd_q && rd_cnt_q == 2'd0;
    wire [7:0] in_capture = loopback ? out_data_q : pb_s2_q;

    wire [15:0] status_word = {8'h00, 6'h00, output_buffer_empty, input_buffer_full};
    wire ext_drive_low = !out_active && !ods_lvl_q && chip_sel; // RL15
    wire [7:0] passive_out = ps1_lvl_q ? status_word[7:0] : out_data_q; // RL12

    wire [4:0] status_set = {serial_in_loaded, serial_out_sent, ids_event, ods_event,
        irq_rise && irq_en_eff_q[0]}; // RL6

    logic [15:0] ctrl_d;
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = (ctrl_q & ~ppio_pkg::CTRL_WRITE_MASK) | (req.wdata & ppio_pkg::CTRL_WRITE_MASK); // RL24 RL25
        end
        if (rd_ser) ctrl_d[ppio_pkg::BIT_SER_IN_FULL] = 1'b0; // RL1
        if (wr_ser) ctrl_d[ppio_pkg::BIT_SER_OUT_EMPTY] = 1'b0; // RL2
        if (rd_data) ctrl_d[ppio_pkg::BIT_IN_STROBE] = 1'b0; // RL3
        if (wr_data) ctrl_d[ppio_pkg::BIT_OUT_STROBE] = 1'b0; // RL5
        if (ack_fell_pending_q && ack_fall) ctrl_d[ppio_pkg::BIT_EXT_IRQ0] = 1'b0; // RL6
        ctrl_d[4:0] = ctrl_d[4:0] | status_set; // set wins over clear
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= ppio_pkg::CTRL_STATUS_RESET; // RL23
            io_config_q <= ppio_pkg::IO_CONFIG_RESET;
            scan_loopback_q <= 1'b0;
            irq_en_eff_q <= 5'h00;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr_iocfg) io_config_q <= req.wdata & ppio_pkg::IO_CONFIG_WRITE_MASK;
            if (jtag_scan_wr) scan_loopback_q <= jtag_scan_loopback; // RL19
            irq_en_eff_q <= ctrl_q[ppio_pkg::BIT_IRQ_EN_HI:ppio_pkg::BIT_IRQ_EN_LO]; // RL7
        end
    end

    // The return-from-interrupt marks which acknowledge fall may clear the pin flag.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) ack_fell_pending_q <= 1'b0;
        else if (irq_return) ack_fell_pending_q <= 1'b1;
        else if (ack_fall) ack_fell_pending_q <= 1'b0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ids_sync_q <= 3'h7;
            ods_sync_q <= 3'h7;
            cs_sync_q <= 3'h7;
            irq_sync_q <= 3'h0;
            ack_sync_q <= 3'h0;
            ps1_sync_q <= 3'h0;
            pb_s1_q <= 8'h00;
            pb_s2_q <= 8'h00;
            ids_lvl_q <= 1'b1;
            ods_lvl_q <= 1'b1;
            cs_lvl_q <= 1'b1;
            irq_lvl_q <= 1'b0;
            ack_lvl_q <= 1'b0;
            ps1_lvl_q <= 1'b0;
        end else begin
            ids_sync_q <= {ids_sync_q[1:0], input_strobe_n_i};
            ods_sync_q <= {ods_sync_q[1:0], output_strobe_n_i};
            cs_sync_q <= {cs_sync_q[1:0], peripheral_select_i[2]};
            irq_sync_q <= {irq_sync_q[1:0], ext_irq0_pin};
            ack_sync_q <= {ack_sync_q[1:0], interrupt_acknowledge};
            ps1_sync_q <= {ps1_sync_q[1:0], peripheral_select_i[1]};
            pb_s1_q <= parallel_bus_i;
            pb_s2_q <= pb_s1_q;
            if (ids_agree) ids_lvl_q <= ids_sync_q[2];
            if (ods_agree) ods_lvl_q <= ods_sync_q[2];
            if (cs_sync_q[1] == cs_sync_q[2]) cs_lvl_q <= cs_sync_q[2];
            if (irq_sync_q[1] == irq_sync_q[2]) irq_lvl_q <= irq_sync_q[2];
            if (ack_sync_q[1] == ack_sync_q[2]) ack_lvl_q <= ack_sync_q[2];
            if (ps1_sync_q[1] == ps1_sync_q[2]) ps1_lvl_q <= ps1_sync_q[2];
        end
    end

    // Active transfers hold the strobe low for a fixed count; a passive port starts none.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            act_wr_q <= 1'b0;
            wr_cnt_q <= 2'd0;
            act_rd_q <= 1'b0;
            rd_cnt_q <= 2'd0;
        end else begin
            if (wr_data && out_active) begin // RL5
                act_wr_q <= 1'b1;
                wr_cnt_q <= 2'(ppio_pkg::ACTIVE_STROBE_CYCLES - 1);
            end else if (act_wr_q && wr_cnt_q != 2'd0) begin
                wr_cnt_q <= wr_cnt_q - 2'd1;
            end else begin
                act_wr_q <= 1'b0;
            end
            if (rd_data && in_active && !loopback) begin // RL4
                act_rd_q <= 1'b1;
                rd_cnt_q <= 2'(ppio_pkg::ACTIVE_STROBE_CYCLES - 1);
            end else if (act_rd_q && rd_cnt_q != 2'd0) begin
                rd_cnt_q <= rd_cnt_q - 2'd1;
            end else begin
                act_rd_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_data_q <= 8'h00;
            in_data_q <= 8'h00;
            channel_q <= 3'h0;
            ids_rise_d1_q <= 1'b0;
            ods_rise_d1_q <= 1'b0;
            act_rd_cap_q <= 1'b0;
        end else begin
            if (wr_data) out_data_q <= req.wdata[7:0];
            if (wr_chan) channel_q <= req.wdata[2:0];
            // Bus data reach the second sync stage one cycle after the strobe ends.
            act_rd_cap_q <= act_rd_end;
            if (ids_event || act_rd_cap_q) in_data_q <= in_capture; // RL14 RL21
            ids_rise_d1_q <= ids_event;
            ods_rise_d1_q <= ods_event;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ibf_q <= 1'b0;
            obe_q <= 1'b0;
        end else begin
            if (in_active) ibf_q <= 1'b0; // RL16
            else if (ids_rise_d1_q) ibf_q <= 1'b1;
            else if (rd_data) ibf_q <= 1'b0;
            if (out_active) obe_q <= 1'b0; // RL17
            else if (ods_rise_d1_q) obe_q <= 1'b1;
            else if (wr_data) obe_q <= 1'b0;
        end
    end
    assign input_buffer_full = ibf_q;
    assign output_buffer_empty = obe_q;

    // Pin drivers; all float in loopback or when the pins serve the other functions.
    wire pins_live = pins_on && !loopback; // RL18 RL21
    assign parallel_bus_oe = pins_live && (out_active ? act_wr_q : ext_drive_low); // RL8
    assign parallel_bus_o = out_active ? out_data_q : passive_out;
    assign output_strobe_n_oe = pins_live && out_active; // RL25
    assign output_strobe_n_o = !act_wr_q;
    assign input_strobe_n_oe = pins_live && in_active; // RL25
    assign input_strobe_n_o = !act_rd_q;
    assign peripheral_select_oe = {pins_live && both_active, pins_live && out_active, pins_live}; // RL9 RL10 RL12
    assign peripheral_select_o = {channel_q[2], channel_q[1],
        both_passive ? (ibf_q | obe_q) : channel_q[0]}; // RL11 RL13
    assign port_pins_selected = pins_on;

    assign irq_request = |(ctrl_q[4:0] & irq_en_eff_q);

    wire [15:0] rd_mux = (req.addr == ppio_pkg::ADDR_CTRL_STATUS) ? ctrl_q :
        (req.addr == ppio_pkg::ADDR_DATA) ? {8'h00, in_data_q} :
        (req.addr == ppio_pkg::ADDR_IO_CONFIG) ? io_config_q :
        (req.addr == ppio_pkg::ADDR_SCAN_CTRL) ? {15'h0000, scan_loopback_q} :
        (req.addr == ppio_pkg::ADDR_CHANNEL) ? {13'h0000, channel_q} : 16'h0000;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) reg_rdata_q <= 16'h0000;
        else reg_rdata_q <= req.rd ? rd_mux : 16'h0000;
    end
    assign reg_rdata = reg_rdata_q;

    property p_ibf_after_rise;
        @(posedge sys_clk) disable iff (rst) ids_event && !in_active ##1 !in_active |=> ibf_q;
    endproperty
    a_ibf_after_rise: assert property (p_ibf_after_rise) else $error("input full not set"); // RL16

    property p_obe_cleared_active;
        @(posedge sys_clk) disable iff (rst) out_active |=> !obe_q;
    endproperty
    a_obe_cleared_active: assert property (p_obe_cleared_active) else $error("output empty in active"); // RL17

    property p_bus_float;
        @(posedge sys_clk) disable iff (rst) parallel_bus_oe |-> !loopback && (act_wr_q || !ods_lvl_q);
    endproperty
    a_bus_float: assert property (p_bus_float) else $error("bus driven without strobe"); // RL8

    property p_strobe_clear_read;
        @(posedge sys_clk) disable iff (rst) rd_data && !ids_event |=> !ctrl_q[ppio_pkg::BIT_IN_STROBE];
    endproperty
    a_strobe_clear_read: assert property (p_strobe_clear_read) else $error("strobe flag not cleared"); // RL3

    property p_no_passive_read;
        @(posedge sys_clk) disable iff (rst) rd_data && !in_active |=> !act_rd_q;
    endproperty
    a_no_passive_read: assert property (p_no_passive_read) else $error("read started when passive"); // RL4

    property p_no_passive_write;
        @(posedge sys_clk) disable iff (rst) wr_data && !out_active && !act_wr_q |=> !act_wr_q;
    endproperty
    a_no_passive_write: assert property (p_no_passive_write) else $error("write started when passive"); // RL5

    property p_en_late;
        @(posedge sys_clk) disable iff (rst) 1'b1 |=> irq_en_eff_q == $past(ctrl_q[9:5]);
    endproperty
    a_en_late: assert property (p_en_late) else $error("enable not one cycle late"); // RL7

    property p_sel0_or;
        @(posedge sys_clk) disable iff (rst) both_passive |-> peripheral_select_o[0] == (ibf_q | obe_q);
    endproperty
    a_sel0_or: assert property (p_sel0_or) else $error("select0 not flag OR"); // RL13

    property p_loop_float;
        @(posedge sys_clk) disable iff (rst) loopback |-> !parallel_bus_oe && !output_strobe_n_oe && !input_strobe_n_oe;
    endproperty
    a_loop_float: assert property (p_loop_float) else $error("pins driven in loopback"); // RL21

    c_loop: cover property (@(posedge sys_clk) disable iff (rst) loopback && ids_event);
    c_passive_wr: cover property (@(posedge sys_clk) disable iff (rst) ids_event && !loopback);
    c_passive_rd: cover property (@(posedge sys_clk) disable iff (rst) ods_event);

endmodule : ppio_port

`default_nettype wire

// ---- tb/ppio_far_end.sv ----
// Behavioural model of the external peripheral on the parallel bus side.
`timescale 1ns/100ps
`default_nettype none

module ppio_far_end (
    input wire logic sys_clk,
    input wire logic [7:0] bus_o,
    input wire logic bus_oe,
    input wire logic [2:0] sel_o,
    input wire logic [2:0] sel_oe,
    input wire logic istb_o,
    input wire logic istb_oe,
    input wire logic ostb_o,
    input wire logic ostb_oe,
    output logic [7:0] bus_i,
    output logic [2:0] sel_i,
    output logic istb_i,
    output logic ostb_i
);
    logic drv = 1'b0;
    logic [7:0] wval = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] resp = 8'h00;
    logic [7:0] got = 8'h00;
    logic [2:0] sval = 3'b111;
    logic is_val = 1'b1;
    logic os_val = 1'b1;
    wire logic ans = istb_oe & ~istb_o;

    // A released bus shows the inverse of its last value, so stale data can never pass for a fresh read.
    assign bus_i = bus_oe ? bus_o : (drv ? wval : (ans ? resp : ~last));
    assign sel_i = (sel_oe & sel_o) | (~sel_oe & sval);
    assign istb_i = istb_oe ? istb_o : is_val;
    assign ostb_i = ostb_oe ? ostb_o : os_val;

    always @(posedge sys_clk) begin
        if (bus_oe | drv | ans) last <= bus_i;
        if (ostb_oe & ~ostb_o) got <= bus_i;
    end

    task ext_write(input logic [7:0] v);
        sval[2] <= 1'b0;
        wval <= v;
        drv <= 1'b1;
        is_val <= 1'b0;
        repeat (4) @(posedge sys_clk);
        is_val <= 1'b1;
        repeat (6) @(posedge sys_clk);
        drv <= 1'b0;
        sval[2] <= 1'b1;
        @(posedge sys_clk);
    endtask : ext_write

    task ext_read(input logic s1, output logic [7:0] v);
        sval[2] <= 1'b0;
        sval[1] <= s1;
        os_val <= 1'b0;
        repeat (6) @(posedge sys_clk);
        v = bus_i;
        os_val <= 1'b1;
        repeat (6) @(posedge sys_clk);
        sval[2] <= 1'b1;
        @(posedge sys_clk);
    endtask : ext_read
endmodule : ppio_far_end

`default_nettype wire

// ---- tb/ppio_port_test.sv ----
// Self-checking bench for the parallel I/O port against the peripheral model.
`timescale 1ns/100ps
`default_nettype none

module ppio_port_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic jtag_scan_wr = 1'b0;
    logic jtag_scan_loopback = 1'b0;
    logic serial_in_loaded = 1'b0;
    logic serial_out_sent = 1'b0;
    logic ext_irq0_pin = 1'b0;
    logic interrupt_acknowledge = 1'b0;
    logic irq_return = 1'b0;
    logic [15:0] reg_rdata;
    logic [7:0] bus_i, bus_o;
    logic [2:0] sel_i, sel_o, sel_oe;
    logic irq_request, bus_oe, istb_i, istb_o, istb_oe, ostb_i, ostb_o, ostb_oe, serial_input_full, serial_output_empty, pins_sel;
    int fails = 0;
    int n_checks = 0;
    logic [15:0] d;
    logic [7:0] b;

    always #4 sys_clk = ~sys_clk;

    ppio_port ppio_port_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .jtag_scan_wr(jtag_scan_wr),
        .jtag_scan_loopback(jtag_scan_loopback), .serial_in_loaded(serial_in_loaded),
        .serial_out_sent(serial_out_sent), .ext_irq0_pin(ext_irq0_pin),
        .interrupt_acknowledge(interrupt_acknowledge), .irq_return(irq_return), .irq_request(irq_request),
        .parallel_bus_i(bus_i), .parallel_bus_o(bus_o), .parallel_bus_oe(bus_oe),
        .peripheral_select_i(sel_i), .peripheral_select_o(sel_o), .peripheral_select_oe(sel_oe),
        .input_strobe_n_i(istb_i), .input_strobe_n_o(istb_o), .input_strobe_n_oe(istb_oe),
        .output_strobe_n_i(ostb_i), .output_strobe_n_o(ostb_o), .output_strobe_n_oe(ostb_oe),
        .input_buffer_full(serial_input_full), .output_buffer_empty(serial_output_empty), .port_pins_selected(pins_sel));

    ppio_far_end ppio_far_end_inst (.sys_clk(sys_clk), .bus_o(bus_o), .bus_oe(bus_oe), .sel_o(sel_o),
        .sel_oe(sel_oe), .istb_o(istb_o), .istb_oe(istb_oe), .ostb_o(ostb_o), .ostb_oe(ostb_oe),
        .bus_i(bus_i), .sel_i(sel_i), .istb_i(istb_i), .ostb_i(ostb_i));

    function automatic logic [15:0] pins();
        return {10'h000, bus_oe, sel_oe, istb_oe, ostb_oe};
    endfunction : pins

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge sys_clk);
    endtask : rd

    // Reads one register and compares the bits that the mask keeps.
    task rchk(input logic [3:0] a, input string n, input logic [15:0] e, input logic [15:0] m);
        rd(a, d);
        chk(n, e, d & m);
    endtask : rchk

    task t_reset();
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "ctrl", 16'h0008, 16'hFFFF);
        rchk(ppio_pkg::ADDR_IO_CONFIG, "io_config", 16'h0000, 16'hFFFF);
        chk("pin enables", 16'h0004, pins());
        chk("pins selected", 16'h0001, {15'h0000, pins_sel});
        wr(ppio_pkg::ADDR_CTRL_STATUS, 16'hFFFF);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "ctrl mask", 16'h1BE8, 16'hFFFF);
        wr(ppio_pkg::ADDR_CTRL_STATUS, 16'h0000);
        rchk(4'h7, "unmapped", 16'h0000, 16'hFFFF);
        $display("test reset finished");
    endtask : t_reset

    task t_serial();
        serial_in_loaded <= 1'b1;
        @(posedge sys_clk);
        serial_in_loaded <= 1'b0;
        @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "in full", 16'h0018, 16'hFFFF);
        rd(ppio_pkg::ADDR_SERIAL_DATA, d);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "in read", 16'h0008, 16'hFFFF);
        wr(ppio_pkg::ADDR_SERIAL_DATA, 16'h0055);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "out write", 16'h0000, 16'hFFFF);
        serial_out_sent <= 1'b1;
        @(posedge sys_clk);
        serial_out_sent <= 1'b0;
        @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "out empty", 16'h0008, 16'hFFFF);
        $display("test serial finished");
    endtask : t_serial

    task t_passive();
        ppio_far_end_inst.ext_write(8'hA5);
        chk("in full pin", 16'h0001, {15'h0000, serial_input_full});
        chk("select0 or", 16'h0001, {15'h0000, sel_o[0]});
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "in strobe", 16'h000C, 16'hFFFF);
        rchk(ppio_pkg::ADDR_DATA, "in data", 16'h00A5, 16'h00FF);
        chk("no active read", 16'h0004, pins());
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "in cleared", 16'h0008, 16'hFFFF);
        chk("in full clear", 16'h0000, {15'h0000, serial_input_full});
        wr(ppio_pkg::ADDR_DATA, 16'h003C);
        chk("no active write", 16'h0004, pins());
        ppio_far_end_inst.ext_read(1'b0, b);
        chk("out data", 16'h003C, {8'h00, b});
        chk("out empty pin", 16'h0001, {15'h0000, serial_output_empty});
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "out strobe", 16'h000A, 16'hFFFF);
        ppio_far_end_inst.ext_read(1'b1, b);
        chk("status byte", 16'h0002, {14'h0000, b[1:0]});
        chk("bus released", 16'h0004, pins());
        wr(ppio_pkg::ADDR_DATA, 16'h0000);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "out cleared", 16'h0008, 16'hFFFF);
        chk("out empty clear", 16'h0000, {15'h0000, serial_output_empty});
        $display("test passive finished");
    endtask : t_passive

    task t_irq();
        wr(ppio_pkg::ADDR_CTRL_STATUS, 16'h0020);
        ext_irq0_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "irq set", 16'h0029, 16'hFFFF);
        chk("irq request", 16'h0001, {15'h0000, irq_request});
        interrupt_acknowledge <= 1'b1;
        repeat (4) @(posedge sys_clk);
        interrupt_acknowledge <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "ack alone", 16'h0029, 16'hFFFF);
        interrupt_acknowledge <= 1'b1;
        repeat (4) @(posedge sys_clk);
        irq_return <= 1'b1;
        @(posedge sys_clk);
        irq_return <= 1'b0;
        @(posedge sys_clk);
        interrupt_acknowledge <= 1'b0;
        ext_irq0_pin <= 1'b0;
        wr(ppio_pkg::ADDR_CTRL_STATUS, 16'h0000);
        repeat (6) @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "irq cleared", 16'h0008, 16'hFFFF);
        ext_irq0_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "irq masked", 16'h0008, 16'hFFFF);
        ext_irq0_pin <= 1'b0;
        $display("test irq finished");
    endtask : t_irq

    task t_active();
        wr(ppio_pkg::ADDR_CTRL_STATUS, 16'h1800);
        wr(ppio_pkg::ADDR_CHANNEL, 16'h0005);
        chk("active pins", 16'h001F, pins());
        chk("channel", 16'h0005, {13'h0000, sel_o});
        wr(ppio_pkg::ADDR_DATA, 16'h0096);
        repeat (6) @(posedge sys_clk);
        chk("written byte", 16'h0096, {8'h00, ppio_far_end_inst.got});
        chk("out empty active", 16'h0000, {15'h0000, serial_output_empty});
        ppio_far_end_inst.resp = 8'h5E;
        rd(ppio_pkg::ADDR_DATA, d);
        repeat (6) @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_DATA, "read byte", 16'h005E, 16'h00FF);
        chk("in full active", 16'h0000, {15'h0000, serial_input_full});
        wr(ppio_pkg::ADDR_CTRL_STATUS, 16'h1000);
        chk("out active pins", 16'h000D, pins());
        chk("low channel", 16'h0001, {14'h0000, sel_o[1:0]});
        $display("test active finished");
    endtask : t_active

    task t_loop();
        wr(ppio_pkg::ADDR_IO_CONFIG, 16'h0001);
        wr(ppio_pkg::ADDR_DATA, 16'h004A);
        chk("loop floats", 16'h0000, pins() & 16'h0023);
        repeat (8) @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_CTRL_STATUS, "loop strobe", 16'h100C, 16'hFFFF);
        rchk(ppio_pkg::ADDR_DATA, "loop data", 16'h004A, 16'h00FF);
        rchk(ppio_pkg::ADDR_IO_CONFIG, "sw loop bit", 16'h0001, 16'hFFFF);
        wr(ppio_pkg::ADDR_IO_CONFIG, 16'h0400);
        chk("pins given up", 16'h0000, {15'h0000, pins_sel});
        wr(ppio_pkg::ADDR_IO_CONFIG, 16'h0000);
        jtag_scan_loopback <= 1'b1;
        jtag_scan_wr <= 1'b1;
        @(posedge sys_clk);
        jtag_scan_wr <= 1'b0;
        wr(ppio_pkg::ADDR_SCAN_CTRL, 16'h0000);
        rchk(ppio_pkg::ADDR_SCAN_CTRL, "scan bit", 16'h0001, 16'hFFFF);
        wr(ppio_pkg::ADDR_DATA, 16'h0077);
        repeat (8) @(posedge sys_clk);
        rchk(ppio_pkg::ADDR_DATA, "scan loop data", 16'h0077, 16'h00FF);
        $display("test loopback finished");
    endtask : t_loop

    task tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // The whole sequence needs well under a thousand cycles; the limit leaves ample margin.
    initial begin
        #60000;
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_serial();
        t_passive();
        t_irq();
        t_active();
        t_loop();
        tally_and_finish();
    end
endmodule : ppio_port_test

`default_nettype wire
